// ---- drive_pid_avr_accel_param_bank.v ----
// apb parameter bank for loop, voltage regulation, operation mode and second ramp times
//
// Summary of operation
// R01: pv source codes 0-3 or 10 only
// R02: polarity 0 gives sp-pv, 1 negates it
// R03: loop output limit 0 to 1000 tenths
// R04: feed-forward source codes 0 through 3
// R05: voltage regulation mode codes 0, 1, 2
// R06: lower class voltages 200/215/220/230/240 only
// R07: higher class voltages 380/400/415/440/460/480 only; reset loads 200 whatever the strap
// R08: operation mode codes 0, 1, 2
// R09: energy-saving tuning 0 to 1000 tenths
// R10: three motors, two-word times 1 to 360000
// R11: illegal writes and reserved addresses rejected
// R12: master writes high then low word together
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "param_bank_defs.vh"

module drive_pid_avr_accel_param_bank (
    // clock and reset
    input wire clk,
    input wire rstn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    // unit strap pin, high for the higher voltage class
    input wire high_voltage_class,
    // loop operands from the control core
    input wire [15:0] setpoint,
    input wire [15:0] process_value,
    // parameter outputs
    output reg [15:0] process_value_source,
    output reg [15:0] loop_error_polarity,
    output reg [15:0] loop_output_limit,
    output reg [15:0] feed_forward_source,
    output reg [15:0] voltage_regulation_mode,
    output reg [15:0] regulated_voltage_select,
    output reg [15:0] operation_mode_select,
    output reg [15:0] energy_saving_tuning,
    output wire [18:0] accel2_time_motor1,
    output wire [18:0] decel2_time_motor1,
    output wire [18:0] accel2_time_motor2,
    output wire [18:0] decel2_time_motor2,
    output wire [18:0] accel2_time_motor3,
    output wire [18:0] decel2_time_motor3,
    // signed loop error
    output reg [16:0] loop_error
);

    // ==========================================================
    // time slot decode
    // ==========================================================
    // returns hit, low-word flag and slot number
    function [4:0] time_slot;
        input [13:0] idx;
        begin
            case (idx)
                `IDX_ACC2_M1_HI: time_slot = 5'b10000;
                `IDX_ACC2_M1_LO: time_slot = 5'b11000;
                `IDX_DEC2_M1_HI: time_slot = 5'b10001;
                `IDX_DEC2_M1_LO: time_slot = 5'b11001;
                `IDX_ACC2_M2_HI: time_slot = 5'b10010;
                `IDX_ACC2_M2_LO: time_slot = 5'b11010;
                `IDX_DEC2_M2_HI: time_slot = 5'b10011;
                `IDX_DEC2_M2_LO: time_slot = 5'b11011;
                `IDX_ACC2_M3_HI: time_slot = 5'b10100;
                `IDX_ACC2_M3_LO: time_slot = 5'b11100;
                `IDX_DEC2_M3_HI: time_slot = 5'b10101;
                `IDX_DEC2_M3_LO: time_slot = 5'b11101;
                default: time_slot = 5'b00000;
            endcase
        end
    endfunction

    // legal nominal voltage for the unit class
    function voltage_ok;
        input hi_class;
        input [15:0] v;
        begin
            voltage_ok = 1'b0;
            if (hi_class) begin
                case (v)
                    `VHI_0: voltage_ok = 1'b1; // R07
                    `VHI_1: voltage_ok = 1'b1; // R07
                    `VHI_2: voltage_ok = 1'b1; // R07
                    `VHI_3: voltage_ok = 1'b1; // R07
                    `VHI_4: voltage_ok = 1'b1; // R07
                    `VHI_5: voltage_ok = 1'b1; // R07
                    default: voltage_ok = 1'b0;
                endcase
            end else begin
                case (v)
                    `VLO_0: voltage_ok = 1'b1; // R06
                    `VLO_1: voltage_ok = 1'b1; // R06
                    `VLO_2: voltage_ok = 1'b1; // R06
                    `VLO_3: voltage_ok = 1'b1; // R06
                    `VLO_4: voltage_ok = 1'b1; // R06
                    default: voltage_ok = 1'b0;
                endcase
            end
        end
    endfunction

    // selector codes of the single-word registers
    localparam SEL_NONE = 4'h0;
    localparam SEL_PV_SOURCE = 4'h1;
    localparam SEL_ERR_POLARITY = 4'h2;
    localparam SEL_OUT_LIMIT = 4'h3;
    localparam SEL_FF_SOURCE = 4'h4;
    localparam SEL_VREG_MODE = 4'h5;
    localparam SEL_VREG_SELECT = 4'h6;
    localparam SEL_OP_MODE = 4'h7;
    localparam SEL_ES_TUNING = 4'h8;
    localparam SEL_STATUS = 4'h9;

    // maps a word index to a single-word register
    function [3:0] reg_code;
        input [13:0] idx;
        begin
            case (idx)
                `IDX_PV_SOURCE: reg_code = SEL_PV_SOURCE;
                `IDX_ERR_POLARITY: reg_code = SEL_ERR_POLARITY;
                `IDX_OUT_LIMIT: reg_code = SEL_OUT_LIMIT;
                `IDX_FF_SOURCE: reg_code = SEL_FF_SOURCE;
                `IDX_VREG_MODE: reg_code = SEL_VREG_MODE;
                `IDX_VREG_SELECT: reg_code = SEL_VREG_SELECT;
                `IDX_OP_MODE: reg_code = SEL_OP_MODE;
                `IDX_ES_TUNING: reg_code = SEL_ES_TUNING;
                `IDX_STATUS: reg_code = SEL_STATUS;
                default: reg_code = SEL_NONE;
            endcase
        end
    endfunction

    // ==========================================================
    // strap synchroniser
    // ==========================================================
    reg class_meta;
    reg class_sync;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            class_meta <= 1'b0;
            class_sync <= 1'b0;
        end else begin
            class_meta <= high_voltage_class;
            class_sync <= class_meta;
        end
    end

    // ==========================================================
    // bus decode
    // ==========================================================
    wire [13:0] idx = paddr[15:2];
    wire aligned = (paddr[1:0] == 2'b00);
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire [15:0] wdat = pwdata[15:0];
    wire [4:0] tslot = time_slot(idx);
    wire [2:0] slot = tslot[2:0];
    wire [3:0] reg_sel = reg_code(idx);
    wire upper_zero = (pwdata[31:16] == 16'h0000);

    reg [18:0] time_val [0:5];
    reg [15:0] pend_high [0:5];
    reg reject_flag;

    wire [31:0] time_word = {pend_high[slot], wdat};

    assign pready = 1'b1;

    // ==========================================================
    // write legality
    // ==========================================================
    reg mapped;
    reg wr_ok;

    always @* begin
        mapped = aligned;
        wr_ok = 1'b0;
        if (tslot[4]) begin
            if (tslot[3]) begin
                wr_ok = upper_zero && (time_word >= `TIME_MIN) && // R10
                    (time_word <= `TIME_MAX); // R10
            end else begin
                wr_ok = upper_zero;
            end
        end else begin
            case (reg_sel)
                SEL_PV_SOURCE: wr_ok = (wdat <= `PV_SRC_MAX) || (wdat == `PV_SRC_CALC); // R01
                SEL_ERR_POLARITY: wr_ok = (wdat <= `POLARITY_MAX); // R02
                SEL_OUT_LIMIT: wr_ok = (wdat <= `TENTHS_MAX); // R03
                SEL_FF_SOURCE: wr_ok = (wdat <= `FF_SRC_MAX); // R04
                SEL_VREG_MODE: wr_ok = (wdat <= `VREG_MODE_MAX); // R05
                SEL_VREG_SELECT: wr_ok = voltage_ok(class_sync, wdat); // R06 R07
                SEL_OP_MODE: wr_ok = (wdat <= `OP_MODE_MAX); // R08
                SEL_ES_TUNING: wr_ok = (wdat <= `TENTHS_MAX); // R09
                SEL_STATUS: wr_ok = 1'b1;
                default: mapped = 1'b0; // R11
            endcase
            if (!upper_zero) begin
                wr_ok = 1'b0;
            end
        end
        if (!aligned) begin
            wr_ok = 1'b0;
        end
    end

    wire do_write = wr & mapped & wr_ok; // R11
    wire bad_write = wr & ~(mapped & wr_ok); // R11

    // ==========================================================
    // parameter registers
    // ==========================================================
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            process_value_source <= `RST_PV_SOURCE;
            loop_error_polarity <= `RST_ERR_POLARITY;
            loop_output_limit <= `RST_OUT_LIMIT;
            feed_forward_source <= `RST_FF_SOURCE;
            voltage_regulation_mode <= `RST_VREG_MODE;
            regulated_voltage_select <= `RST_VREG_LO;
            operation_mode_select <= `RST_OP_MODE;
            energy_saving_tuning <= `RST_ES_TUNING;
        end else if (do_write && !tslot[4]) begin
            case (reg_sel)
                SEL_PV_SOURCE: process_value_source <= wdat; // R01
                SEL_ERR_POLARITY: loop_error_polarity <= wdat; // R02
                SEL_OUT_LIMIT: loop_output_limit <= wdat; // R03
                SEL_FF_SOURCE: feed_forward_source <= wdat; // R04
                SEL_VREG_MODE: voltage_regulation_mode <= wdat; // R05
                SEL_VREG_SELECT: regulated_voltage_select <= wdat; // R06 R07
                SEL_OP_MODE: operation_mode_select <= wdat; // R08
                SEL_ES_TUNING: energy_saving_tuning <= wdat; // R09
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // two-word times
    // ==========================================================
    // high word is staged; the low word write commits both
    integer i;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (i = 0; i < 6; i = i + 1) begin
                time_val[i] <= `RST_TIME;
                pend_high[i] <= 16'h0000;
            end
        end else if (do_write && tslot[4]) begin
            if (tslot[3]) begin
                time_val[slot] <= time_word[18:0]; // R10
            end else begin
                pend_high[slot] <= wdat; // R12
            end
        end
    end

    assign accel2_time_motor1 = time_val[0];
    assign decel2_time_motor1 = time_val[1];
    assign accel2_time_motor2 = time_val[2];
    assign decel2_time_motor2 = time_val[3];
    assign accel2_time_motor3 = time_val[4];
    assign decel2_time_motor3 = time_val[5];

    // ==========================================================
    // status
    // ==========================================================
    // a rejection in the clearing cycle wins over the clear
    wire clear_reject = do_write && (idx == `IDX_STATUS) && pwdata[`STAT_REJECT_BIT];

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reject_flag <= 1'b0;
        end else if (bad_write) begin
            reject_flag <= 1'b1; // R11
        end else if (clear_reject) begin
            reject_flag <= 1'b0;
        end
    end

    // ==========================================================
    // read path
    // ==========================================================
    // widens a 16-bit register for the read bus
    function [31:0] zext16;
        input [15:0] x;
        begin
            zext16 = {16'h0000, x};
        end
    endfunction

    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h00000000;
        if (tslot[4]) begin
            if (tslot[3]) begin
                rd_mux = zext16(time_val[slot][15:0]);
            end else begin
                rd_mux = {29'h00000000, time_val[slot][18:16]};
            end
        end else begin
            case (reg_sel)
                SEL_PV_SOURCE: rd_mux = zext16(process_value_source);
                SEL_ERR_POLARITY: rd_mux = zext16(loop_error_polarity);
                SEL_OUT_LIMIT: rd_mux = zext16(loop_output_limit);
                SEL_FF_SOURCE: rd_mux = zext16(feed_forward_source);
                SEL_VREG_MODE: rd_mux = zext16(voltage_regulation_mode);
                SEL_VREG_SELECT: rd_mux = zext16(regulated_voltage_select);
                SEL_OP_MODE: rd_mux = zext16(operation_mode_select);
                SEL_ES_TUNING: rd_mux = zext16(energy_saving_tuning);
                SEL_STATUS: rd_mux = {30'h00000000, reject_flag, class_sync};
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    // read data captured in the setup cycle, stands through the access cycle
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite && mapped) begin
            prdata <= rd_mux;
        end else begin
            prdata <= 32'h00000000;
        end
    end

    always @* begin
        pslverr = 1'b0;
        if (access) begin
            if (pwrite) begin
                pslverr = bad_write; // R11
            end else begin
                pslverr = ~mapped; // R11
            end
        end
    end

    // ==========================================================
    // loop error
    // ==========================================================
    // sign extension of a loop operand
    function [16:0] sext17;
        input [15:0] x;
        begin
            sext17 = {x[15], x};
        end
    endfunction

    wire [16:0] sp_ext = sext17(setpoint);
    wire [16:0] pv_ext = sext17(process_value);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            loop_error <= 17'h00000;
        end else if (loop_error_polarity[0]) begin
            loop_error <= pv_ext - sp_ext; // R02
        end else begin
            loop_error <= sp_ext - pv_ext; // R02
        end
    end

endmodule
`default_nettype wire

// ---- param_bank_defs.vh ----
// register indices, limits and reset values of the parameter bank
`ifndef PARAM_BANK_DEFS_VH
`define PARAM_BANK_DEFS_VH

// register indices (byte address is four times the index)
`define IDX_PV_SOURCE 14'h1264
`define IDX_ERR_POLARITY 14'h1265
`define IDX_OUT_LIMIT 14'h1266
`define IDX_FF_SOURCE 14'h1267
`define IDX_VREG_MODE 14'h1269
`define IDX_VREG_SELECT 14'h126A
`define IDX_OP_MODE 14'h126D
`define IDX_ES_TUNING 14'h126E
`define IDX_ACC2_M1_HI 14'h1274
`define IDX_ACC2_M1_LO 14'h1275
`define IDX_DEC2_M1_HI 14'h1276
`define IDX_DEC2_M1_LO 14'h1277
`define IDX_ACC2_M2_HI 14'h226F
`define IDX_ACC2_M2_LO 14'h2270
`define IDX_DEC2_M2_HI 14'h2271
`define IDX_DEC2_M2_LO 14'h2272
`define IDX_ACC2_M3_HI 14'h326D
`define IDX_ACC2_M3_LO 14'h326E
`define IDX_DEC2_M3_HI 14'h326F
`define IDX_DEC2_M3_LO 14'h3270
`define IDX_STATUS 14'h0000

// status fields
`define STAT_CLASS_BIT 0
`define STAT_REJECT_BIT 1

// code limits
`define PV_SRC_MAX 16'h0003
`define PV_SRC_CALC 16'h000A
`define POLARITY_MAX 16'h0001
`define TENTHS_MAX 16'h03E8
`define FF_SRC_MAX 16'h0003
`define VREG_MODE_MAX 16'h0002
`define OP_MODE_MAX 16'h0002
`define TIME_MIN 32'h00000001
`define TIME_MAX 32'h00057E40

// nominal voltages, lower class
`define VLO_0 16'h00C8
`define VLO_1 16'h00D7
`define VLO_2 16'h00DC
`define VLO_3 16'h00E6
`define VLO_4 16'h00F0
// nominal voltages, higher class
`define VHI_0 16'h017C
`define VHI_1 16'h0190
`define VHI_2 16'h019F
`define VHI_3 16'h01B8
`define VHI_4 16'h01CC
`define VHI_5 16'h01E0

// reset values
`define RST_PV_SOURCE 16'h0000
`define RST_ERR_POLARITY 16'h0000
`define RST_OUT_LIMIT 16'h03E8
`define RST_FF_SOURCE 16'h0000
`define RST_VREG_MODE 16'h0000
`define RST_VREG_LO 16'h00C8
`define RST_VREG_HI 16'h0190
`define RST_OP_MODE 16'h0000
`define RST_ES_TUNING 16'h01F4
`define RST_TIME 19'h005DC

`endif

// ---- net_master.sv ----
// apb master model standing in for the network master
`timescale 1ns/1ps
`default_nettype none
module net_master (
    // clock
    input wire logic clk,
    // apb request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [15:0] paddr,
    output logic [31:0] pwdata,
    // apb answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'hFFFC;
        pwdata = 32'h0;
    end
    // ====================
    // one transfer, held until pready is seen high or 64 cycles have passed
    task automatic xfer(input logic w, input logic [13:0] ix, input logic [31:0] d,
        output logic [31:0] q, output logic e, output logic hung);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        q = prdata;
        e = pslverr;
        hung = (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~{ix, 2'b00};
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ---- drive_pid_avr_accel_param_bank_assertions.sv ----
// port checks of the parameter bank
`timescale 1ns/1ps
`default_nettype none
`include "param_bank_defs.vh"
module param_bank_checker (
    // clock and reset
    input wire clk,
    input wire rstn,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    input wire pslverr,
    // loop and parameters
    input wire [15:0] setpoint,
    input wire [15:0] process_value,
    input wire [15:0] process_value_source,
    input wire [15:0] loop_error_polarity,
    input wire [15:0] loop_output_limit,
    input wire [15:0] feed_forward_source,
    input wire [15:0] voltage_regulation_mode,
    input wire [15:0] regulated_voltage_select,
    input wire [15:0] operation_mode_select,
    input wire [15:0] energy_saving_tuning,
    input wire [18:0] accel2_time_motor1,
    input wire [16:0] loop_error
);
    // ====================
    // decode
    wire wr = psel && penable && pwrite;
    wire [13:0] ix = paddr[15:2];
    wire [16:0] diff = {setpoint[15], setpoint} - {process_value[15], process_value};
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_pv_codes: assert property (process_value_source <= 3 || process_value_source == 10)
        else $error("pv source code illegal");
    a_err_sign: assert property (1 |=> loop_error == ($past(loop_error_polarity[0]) ? -$past(diff) : $past(diff)))
        else $error("loop error sign wrong");
    a_limit_write: assert property (wr && ix == `IDX_OUT_LIMIT && pwdata <= 1000 |=>
        loop_output_limit == $past(pwdata[15:0])) else $error("limit not stored");
    a_limit_reject: assert property (wr && ix == `IDX_OUT_LIMIT && pwdata > 1000 |->
        pslverr ##1 $stable(loop_output_limit)) else $error("bad limit taken");
    a_code_ranges: assert property (feed_forward_source <= 3 && voltage_regulation_mode <= 2
        && operation_mode_select <= 2) else $error("mode code illegal");
    a_tuning_range: assert property (energy_saving_tuning <= 1000) else $error("tuning range");
    a_time_range: assert property (accel2_time_motor1 >= 1 && accel2_time_motor1 <= 360000)
        else $error("time range");
    a_reserved_refuse: assert property (psel && penable && ix == 14'h1268 |-> pslverr)
        else $error("reserved not refused");
    a_vreg_store: assert property (wr && ix == `IDX_VREG_SELECT && !pslverr |=>
        regulated_voltage_select == $past(pwdata[15:0])) else $error("voltage not stored");
    a_vreg_keep: assert property (wr && ix == `IDX_VREG_SELECT && pslverr |=>
        $stable(regulated_voltage_select)) else $error("bad voltage taken");
endmodule
bind drive_pid_avr_accel_param_bank param_bank_checker chk (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .setpoint(setpoint), .process_value(process_value), .process_value_source(process_value_source),
    .loop_error_polarity(loop_error_polarity), .loop_output_limit(loop_output_limit),
    .feed_forward_source(feed_forward_source), .voltage_regulation_mode(voltage_regulation_mode),
    .regulated_voltage_select(regulated_voltage_select),
    .operation_mode_select(operation_mode_select), .energy_saving_tuning(energy_saving_tuning),
    .accel2_time_motor1(accel2_time_motor1), .loop_error(loop_error));
`default_nettype wire

// ---- tb_drive_pid_avr_accel_param_bank.sv ----
// self-checking bench of the parameter bank
`timescale 1ns/1ps
`default_nettype none
`include "param_bank_defs.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_drive_pid_avr_accel_param_bank;
    // ====================
    // signals
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hvc = 1'b0;
    logic [15:0] sp = 16'h0000;
    logic [15:0] pv = 16'h0000;
    wire psel, penable, pwrite, pready, pslverr;
    wire [15:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [18:0] tm [6];
    wire [16:0] lerr;
    logic [13:0] hix [6] = '{`IDX_ACC2_M1_HI, `IDX_DEC2_M1_HI, `IDX_ACC2_M2_HI, `IDX_DEC2_M2_HI,
        `IDX_ACC2_M3_HI, `IDX_DEC2_M3_HI};
    logic [13:0] rsv [3] = '{14'h1268, 14'h126B, 14'h126F};
    int lo_v [7] = '{200, 215, 220, 230, 240, 210, 380};
    int hi_v [7] = '{380, 400, 415, 440, 460, 480, 200};
    int lim_v [4] = '{0, 1000, 1001, 32'h00010005};
    int num_errors = 0;
    int total_checks = 0;
    always #12.5 clk = ~clk;
    drive_pid_avr_accel_param_bank dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .high_voltage_class(hvc), .setpoint(sp), .process_value(pv),
        .process_value_source(), .loop_error_polarity(), .loop_output_limit(),
        .feed_forward_source(), .voltage_regulation_mode(), .regulated_voltage_select(),
        .operation_mode_select(), .energy_saving_tuning(), .accel2_time_motor1(tm[0]),
        .decel2_time_motor1(tm[1]), .accel2_time_motor2(tm[2]), .decel2_time_motor2(tm[3]),
        .accel2_time_motor3(tm[4]), .decel2_time_motor3(tm[5]), .loop_error(lerr));
    net_master master (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ====================
    // tasks
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic xf(input logic w, input logic [13:0] ix, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        logic h;
        master.xfer(w, ix, d, q, e, h);
        if (h) begin
            num_errors++;
            report_and_stop;
        end
    endtask
    task automatic rdchk(input logic [13:0] ix, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        xf(1'b0, ix, 32'h0, q, e);
        `CHK("read", x, q)
    endtask
    task automatic try(input logic [13:0] ix, input logic [31:0] d, input logic ok);
        logic [31:0] p;
        logic [31:0] q;
        logic e;
        xf(1'b0, ix, 32'h0, p, e);
        xf(1'b1, ix, d, q, e);
        `CHK("refusal", !ok, e)
        rdchk(ix, ok ? d : p);
    endtask
    task automatic pair(input logic [13:0] ix, input logic [31:0] d, input logic ok);
        logic [31:0] q;
        logic e;
        xf(1'b1, ix, {16'h0, d[31:16]}, q, e);
        xf(1'b1, ix + 14'h1, {16'h0, d[15:0]}, q, e);
        `CHK("time refusal", !ok, e)
        @(negedge clk);
    endtask
    // ====================
    // tests
    initial begin
        logic [31:0] q;
        logic e;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rdchk(`IDX_OUT_LIMIT, {16'h0, `RST_OUT_LIMIT});
        rdchk(`IDX_ES_TUNING, {16'h0, `RST_ES_TUNING});
        rdchk(`IDX_ACC2_M1_LO, {13'h0, `RST_TIME});
        $display("reset test done");
        for (int v = 0; v < 12; v++) try(`IDX_PV_SOURCE, v, v <= 3 || v == 10);
        for (int v = 0; v < 5; v++) begin
            try(`IDX_FF_SOURCE, v, v < 4);
            try(`IDX_VREG_MODE, v, v < 3);
            try(`IDX_OP_MODE, v, v < 3);
        end
        foreach (lim_v[i]) begin
            try(`IDX_OUT_LIMIT, lim_v[i], lim_v[i] <= 1000);
            try(`IDX_ES_TUNING, lim_v[i], lim_v[i] <= 1000);
        end
        foreach (rsv[i]) begin
            xf(1'b1, rsv[i], 32'h1, q, e);
            `CHK("reserved", 1'b1, e)
        end
        $display("code test done");
        foreach (lo_v[i]) try(`IDX_VREG_SELECT, lo_v[i], i < 5);
        hvc <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (hi_v[i]) try(`IDX_VREG_SELECT, hi_v[i], i < 6);
        $display("voltage test done");
        rdchk(`IDX_STATUS, 32'h3);
        xf(1'b1, `IDX_STATUS, 32'h2, q, e);
        `CHK("status clear", 1'b0, e)
        rdchk(`IDX_STATUS, 32'h1);
        $display("status test done");
        foreach (hix[i]) begin
            pair(hix[i], 32'd360000, 1'b1);
            `CHK("time", 19'h57E40, tm[i])
            pair(hix[i], 32'd360001, 1'b0);
            pair(hix[i], 32'd0, 1'b0);
            `CHK("time kept", 19'h57E40, tm[i])
            xf(1'b1, hix[i], 32'h0, q, e);
            rdchk(hix[i], 32'h5);
            pair(hix[i], 32'd1, 1'b1);
            `CHK("time min", 19'h00001, tm[i])
        end
        $display("time test done");
        try(`IDX_ERR_POLARITY, 32'h0, 1'b1);
        sp <= 16'h0005;
        pv <= 16'h0009;
        repeat (3) @(posedge clk);
        `CHK("loop error", 17'h1FFFC, lerr)
        try(`IDX_ERR_POLARITY, 32'h1, 1'b1);
        try(`IDX_ERR_POLARITY, 32'h2, 1'b0);
        `CHK("loop error", 17'h00004, lerr)
        $display("loop test done");
        report_and_stop;
    end
endmodule
`default_nettype wire
